/* File: hdl/pdqlt_detect.sv */
/*
 Detect quiet/active sequencing of the link trainer with lane tie-off.
 Assumes the receiver-detect engine answers each request with a done pulse.
*/
`timescale 1ns/1ns
module pdqlt_detect #(
   parameter int QUIET_CYC = pdqlt_pkg::QUIET_TIMEOUT_CYC,
   parameter int MIN_CYC   = pdqlt_pkg::QUIET_MIN_CYC
) (
   // Clock and reset
   input  wire logic                      mclk_i,
   input  wire logic                      sys_rst_i,
   // Configuration
   input  wire logic [3:0]                lane_assign_i,
   input  wire logic                      quiet_min_delay_enable_i,
   // SERDES status
   input  wire pdqlt_pkg::pdqlt_lane_st_t serdes_st_i,
   // Receiver detect handshake
   input  wire logic                      det_done_i,
   output      logic                      det_req_o,
   // Status
   output      pdqlt_pkg::pdqlt_state_t   state_o,
   output      logic                      link_found_o
);
   initial begin
      if (QUIET_CYC < 1 || MIN_CYC < 1 || QUIET_CYC >= (1 << 24) || MIN_CYC >= (1 << 24)) begin
         $error("quiet counts out of range");
      end
   end

   typedef struct packed {
      pdqlt_pkg::pdqlt_state_t state;
      logic [23:0]             cnt;
      logic                    first;
      logic                    req;
      logic                    found;
   } pdqlt_det_st_t;
   pdqlt_det_st_t           st_q, st_d;
   pdqlt_pkg::pdqlt_lane_st_t lanes;
   logic                    exit_ok;

   pdqlt_lane_tie #(.NL(4)) u_tie (
      .mclk_i        (mclk_i),
      .sys_rst_i     (sys_rst_i),
      .lane_assign_i (lane_assign_i),
      .raw_i         (serdes_st_i),
      .tied_o        (lanes)
   );

   always_comb begin
      st_d  = st_q;
      st_d.req = 1'b0;
      // full quiet wait
      // Lane activity is deliberately ignored in quiet: an early exit skipped the
      // discharge time and made every later detection fail.
      exit_ok = (st_q.cnt >= 24'(QUIET_CYC - 1));
      if (quiet_min_delay_enable_i && st_q.cnt < 24'(MIN_CYC - 1)) begin
         exit_ok = 1'b0;
      end
      case (st_q.state)
         pdqlt_pkg::PDQLT_QUIET: begin
            st_d.cnt = st_q.cnt + 24'h000001;
            if (exit_ok) begin
               st_d.state = pdqlt_pkg::PDQLT_ACTIVE;
               st_d.req   = 1'b1;
               st_d.cnt   = '0;
            end
         end
         pdqlt_pkg::PDQLT_ACTIVE: begin
            st_d.state = pdqlt_pkg::PDQLT_WAIT;
         end
         pdqlt_pkg::PDQLT_WAIT: begin
            if (det_done_i) begin
               if (lanes.rx_present != 4'h0) begin
                  st_d.state = pdqlt_pkg::PDQLT_DONE;
                  st_d.found = 1'b1;
               end else begin
                  st_d.state = pdqlt_pkg::PDQLT_QUIET;
                  st_d.first = 1'b0;
                  st_d.cnt   = '0;
               end
            end
         end
         default: begin
            st_d.state = pdqlt_pkg::PDQLT_DONE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st_q <= '{state: pdqlt_pkg::PDQLT_QUIET, cnt: '0, first: 1'b1, req: 1'b0, found: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign det_req_o    = st_q.req;
   assign state_o      = st_q.state;
   assign link_found_o = st_q.found;

   a_quiet_full_wait: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (st_q.state == pdqlt_pkg::PDQLT_QUIET && st_d.state == pdqlt_pkg::PDQLT_ACTIVE)
      |-> st_q.cnt >= 24'(QUIET_CYC - 1))
      else $error("quiet left before timeout");
   a_min_delay_kept: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (quiet_min_delay_enable_i && st_q.state == pdqlt_pkg::PDQLT_QUIET
       && st_d.state == pdqlt_pkg::PDQLT_ACTIVE) |-> st_q.cnt >= 24'(MIN_CYC - 1))
      else $error("minimum quiet delay violated");
   a_fail_to_quiet: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (st_q.state == pdqlt_pkg::PDQLT_WAIT && det_done_i && lanes.rx_present == 4'h0)
      |=> st_q.state == pdqlt_pkg::PDQLT_QUIET && st_q.cnt == '0)
      else $error("failed detect did not return to quiet");
   a_req_spacing: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      det_req_o |=> !det_req_o [*2])
      else $error("detect requests back to back");
endmodule

/* File: hdl/pdqlt_lane_tie.sv */
/*
 Per-lane status tie-off and pin synchroniser.
 Assumes raw SERDES status arrives from outside the clock domain.
*/
`timescale 1ns/1ns
module pdqlt_lane_tie #(
   parameter int NL = pdqlt_pkg::NUM_LANES
) (
   // Clock and reset
   input  wire logic                     mclk_i,
   input  wire logic                     sys_rst_i,
   // Lane configuration and status
   input  wire logic [NL-1:0]            lane_assign_i,
   input  wire pdqlt_pkg::pdqlt_lane_st_t raw_i,
   output      pdqlt_pkg::pdqlt_lane_st_t tied_o
);
   typedef struct packed {
      pdqlt_pkg::pdqlt_lane_st_t s1, s2, s3, stable, tied;
   } pdqlt_tie_st_t;
   pdqlt_tie_st_t st_q, st_d;

   always_comb begin
      st_d        = st_q;
      st_d.s1     = raw_i;
      st_d.s2     = st_q.s1;
      st_d.s3     = st_q.s2;
      for (int i = 0; i < NL; i++) begin
         if (st_q.s2.elec_idle[i] == st_q.s3.elec_idle[i]) begin
            st_d.stable.elec_idle[i] = st_q.s3.elec_idle[i];
         end
         if (st_q.s2.rx_present[i] == st_q.s3.rx_present[i]) begin
            st_d.stable.rx_present[i] = st_q.s3.rx_present[i];
         end
      end
      // idle tie-off
      // Unassigned lanes read as idle with no receiver, so they cannot wake the trainer.
      st_d.tied.elec_idle  = st_q.stable.elec_idle | ~lane_assign_i;
      st_d.tied.rx_present = st_q.stable.rx_present & lane_assign_i;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st_q <= '{default: '1, s1: '1, s2: '1, s3: '1, stable: '1, tied: '1};
         st_q.s1.rx_present     <= '0;
         st_q.s2.rx_present     <= '0;
         st_q.s3.rx_present     <= '0;
         st_q.stable.rx_present <= '0;
         st_q.tied.rx_present   <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tied_o = st_q.tied;

   a_unassigned_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      ##1 $stable(lane_assign_i) |-> ((tied_o.elec_idle | lane_assign_i) == '1))
      else $error("unassigned lane not tied idle");
endmodule

/* File: hdl/pdqlt_pkg.sv */
/*
 Constants and carrier types for the receiver-detect section of the link trainer.
 Assumes a single 100 MHz clock and a synchronous active-high reset.
*/
package pdqlt_pkg;
   localparam int  CLK_MHZ         = 100;
   localparam int  QUIET_TIMEOUT_US = 12000;
   localparam int  QUIET_MIN_US    = 2000;
   localparam int  QUIET_TIMEOUT_CYC = QUIET_TIMEOUT_US * CLK_MHZ;
   localparam int  QUIET_MIN_CYC   = QUIET_MIN_US * CLK_MHZ;
   localparam int  NUM_LANES       = 4;
   localparam int  CNT_W           = 21;
   localparam logic [3:0] ASSIGN_RST = 4'hF;

   typedef enum logic [1:0] {
      PDQLT_QUIET  = 2'h0,
      PDQLT_ACTIVE = 2'h1,
      PDQLT_WAIT   = 2'h3,
      PDQLT_DONE   = 2'h2
   } pdqlt_state_t;

   typedef struct packed {
      logic [NUM_LANES-1:0] elec_idle;
      logic [NUM_LANES-1:0] rx_present;
   } pdqlt_lane_st_t;
endpackage

/* File: sim/pdqlt_partner.sv */
/*
 Far-side model: answers receiver detect and shows lane status.
 Assumes requests arrive as single-cycle pulses.
*/
`timescale 1ns/1ns
module pdqlt_partner (
   // Clock
   input  wire logic                 mclk_i,
   // Detect handshake and presence
   input  wire logic                 det_req_i,
   input  wire logic [3:0]           present_i,
   input  wire logic [3:0]           delay_i,
   output logic                      det_done_o,
   output pdqlt_pkg::pdqlt_lane_st_t st_o
);
   logic [3:0] cnt_q;
   initial begin
      cnt_q = 4'h0;
      det_done_o = 1'b0;
      st_o = '{elec_idle: 4'h5, rx_present: 4'h0};
   end
   // Idle indication flips every cycle, so the lane synchroniser never accepts it and holds every lane at idle.
   always @(posedge mclk_i) begin
      det_done_o <= (cnt_q == 4'h1);
      cnt_q <= det_req_i ? delay_i : cnt_q - {3'h0, cnt_q != 4'h0};
      st_o.elec_idle <= ~st_o.elec_idle;
      st_o.rx_present <= present_i;
   end
endmodule

/* File: sim/tb_top.sv */
/*
 Self-checking bench for the detect sequencer.
 Assumes shortened quiet counts set as parameters here.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t", $time); end end
module tb_top;
   localparam int QC = 40;
   localparam int MC = 10;
   logic                      mclk_i = 1'b0;
   logic                      sys_rst_i = 1'b1;
   logic [3:0]                asg = 4'h0;
   logic [3:0]                pres = 4'h0;
   logic [3:0]                dly = 4'h2;
   logic                      en = 1'b0;
   logic                      req;
   logic                      done;
   logic                      found;
   pdqlt_pkg::pdqlt_lane_st_t st;
   pdqlt_pkg::pdqlt_state_t   state;
   int                        error_cnt = 0;
   int                        n_tests = 0;
   int                        cyc = 0;
   initial forever #5 mclk_i = ~mclk_i;
   pdqlt_detect #(.QUIET_CYC(QC), .MIN_CYC(MC)) pdqlt_detect_inst (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .lane_assign_i(asg), .quiet_min_delay_enable_i(en),
      .serdes_st_i(st), .det_done_i(done), .det_req_o(req), .state_o(state),
      .link_found_o(found));
   pdqlt_partner pdqlt_partner_inst (.mclk_i(mclk_i), .det_req_i(req), .present_i(pres),
      .delay_i(dly), .det_done_o(done), .st_o(st));
   task automatic tally_and_finish();
      $display("checks %0d bad %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   function automatic logic exp_found(logic [3:0] a, logic [3:0] p);
      return |(a & p);
   endfunction
   task automatic wait_req(output int n);
      n = 0;
      do begin
         @(negedge mclk_i);
         n++;
      end while (req !== 1'b1 && n < 200);
   endtask
   // Each run resets, then waits for two detect requests, giving up on each wait after 200 cycles.
   task automatic run(logic [3:0] a, logic [3:0] p, logic e);
      int  n;
      logic f;
      f = exp_found(a, p);
      @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      asg <= a;
      pres <= p;
      en <= e;
      dly <= 4'($urandom_range(2, 7));
      repeat (8) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      wait_req(n);
      `CHK(n >= QC - 2, 1'b1)
      wait_req(n);
      if (f) begin
         `CHK(found, 1'b1)
         `CHK(state, pdqlt_pkg::PDQLT_DONE)
      end else begin
         `CHK(n >= QC && n <= QC + 12, 1'b1)
         `CHK(found, 1'b0)
      end
      $display("run asg %h pres %h done", a, p);
   endtask
   initial begin
      cyc = $urandom(32'h047fb712);
      cyc = 0;
      run(4'h3, 4'h2, 1'b1);
      run(4'hC, 4'h2, 1'b0);
      run(4'h3, 4'h0, 1'b1);
      for (int i = 0; i < 6; i++) run(4'($urandom), 4'($urandom), 1'($urandom));
      tally_and_finish();
   end
endmodule
